// file: core/tmhl_core.sv
// Purpose: Mode control of an 8-bit period timer with hardware limit functions.
// Assumes: One clock; the trigger comes from outside this clock's domain.
// Notes:   The timer clock is core_clk_i divided by the prescaler enable.
//
// What this block does
// - Software gate counts while run bit set.
// - Count equal period clears to zero next.
// - Hardware gate equals software gate plus trigger.
// - Mode 00001 pauses while trigger high.
// - Mode 00010 pauses while trigger low.
// - Gating pauses stretch the period seen.
// - Software one-shot clears run after period match.
// - Edge one-shot starts on fresh edge.
// - Later edges reset; resume two clocks after.
// - Level one-shot holds reset, starts on release.
// - Monostable stops at zero, keeps run set.
// - Run and trigger delayed two timer clocks.
// - Instruction clock: one period sync delay.
// - Zero select fields give 1:1 scaling.
// - Debug mode ignores the trigger.
//
// The address-and-strobe port and the register addresses were decided locally.
`include "tmhl_regs.svh"

module tmhl_core #(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             sys_rst_i,
    // Register port
    input  wire logic [7:0]       addr_i,
    input  wire logic [7:0]       wr_data_i,
    input  wire logic             wr_en_i,
    input  wire logic             rd_en_i,
    output logic      [7:0]       rd_data_o,
    // Trigger and system state
    input  wire logic             ext_trigger_signal_i,
    input  wire logic             instr_clk_sel_i,
    input  wire logic             debug_mode_i,
    // Timer outputs
    output logic      [CNT_W-1:0] count_value_o,
    output logic                  run_o,
    output logic                  period_match_o,
    output logic                  postscaled_o
);
    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    tmhl_pkg::tmhl_ctrl_t  ctrl_r,   ctrl_nxt;
    tmhl_pkg::tmhl_phase_t phase_r,  phase_nxt;
    tmhl_pkg::tmhl_dec_t   dec;
    logic [4:0]            mode_r,   mode_nxt;
    logic [CNT_W-1:0]      period_r, period_nxt;
    logic [CNT_W-1:0]      count_r,  count_nxt;
    logic [1:0]            hold_r,   hold_nxt;
    logic [6:0]            pre_r,    pre_nxt;
    logic [3:0]            post_r,   post_nxt;
    logic                  run_p1_r, run_p1_nxt;
    logic                  run_p2_r, run_p2_nxt;
    logic                  trg_p1_r, trg_p1_nxt;
    logic                  trg_p2_r, trg_p2_nxt;
    logic                  trg_prv_r, trg_prv_nxt;
    logic                  match_r,  match_nxt;
    logic                  pscl_r,   pscl_nxt;
    logic [7:0]            rdat_r,   rdat_nxt;

    logic                  trg_sync;
    logic                  tick;
    logic                  stage_en;
    logic                  run_eff;
    logic                  trg_eff;
    logic                  rise;
    logic                  fall;
    logic                  at_period;
    logic                  gate;
    logic                  roll;
    logic                  hw_clr_run;
    logic [6:0]            pre_lim;

    tmhl_sync u_trg_sync (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .async_i    (ext_trigger_signal_i),
        .sync_o     (trg_sync)
    );

    // ------------------------------------------------------------------------
    // Prescaler and synchronisation stages
    // ------------------------------------------------------------------------
    // A select of zero gives a limit of zero, so every clock is a tick.
    assign pre_lim  = 7'((`TMHL_ONE8 << ctrl_r.prescale_select) - `TMHL_ONE8);
    assign tick     = (pre_r == pre_lim);
    // With the instruction clock the stages move every cycle; otherwise on ticks.
    assign stage_en = instr_clk_sel_i | tick;
    assign run_eff  = instr_clk_sel_i ? run_p1_r : run_p2_r;
    assign trg_eff  = instr_clk_sel_i ? trg_p1_r : trg_p2_r;
    assign rise     = trg_eff & ~trg_prv_r;
    assign fall     = ~trg_eff & trg_prv_r;
    assign at_period = (count_r == period_r);

    always_comb begin
        pre_nxt    = tick ? `TMHL_ZERO7 : pre_r + `TMHL_ONE7;
        run_p1_nxt = run_p1_r;
        run_p2_nxt = run_p2_r;
        trg_p1_nxt = trg_p1_r;
        trg_p2_nxt = trg_p2_r;
        trg_prv_nxt = trg_prv_r;
        if (stage_en) begin
            run_p1_nxt = ctrl_r.run;
            run_p2_nxt = run_p1_r;
        end
        // In debug the trigger stages freeze, so no edge or level change is seen.
        if (stage_en && !debug_mode_i) begin
            trg_p1_nxt = trg_sync;
            trg_p2_nxt = trg_p1_r;
        end
        if (tick) begin
            trg_prv_nxt = trg_eff;
        end
        // A hardware clear of run must not be undone by stale pipeline copies.
        if (hw_clr_run) begin
            run_p1_nxt = 1'b0;
            run_p2_nxt = 1'b0;
        end
        if (wr_en_i && addr_i == `TMHL_ADDR_COUNT) begin
            pre_nxt = `TMHL_ZERO7;
        end
    end

    // ------------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------------
    always_comb begin
        dec = '0;
        case (mode_r[4:3])
            `TMHL_GRP_FREE: begin
                dec.gate_mode = 1'b1;
            end
            `TMHL_GRP_ONE: begin
                dec.clr_run = 1'b1;
                case (mode_r[2:0])
                    `TMHL_LO_SW:     dec.start_ev = 1'b1;
                    `TMHL_LO_RISE:   dec.start_ev = rise;
                    `TMHL_LO_FALL:   dec.start_ev = fall;
                    `TMHL_LO_ANY:    dec.start_ev = rise | fall;
                    `TMHL_LO_ERST_R: begin
                        dec.start_ev = rise;
                        dec.rst_edge = rise;
                    end
                    `TMHL_LO_ERST_F: begin
                        dec.start_ev = fall;
                        dec.rst_edge = fall;
                    end
                    `TMHL_LO_LVL_A: begin
                        dec.start_ev = rise;
                        dec.rst_lvl  = ~trg_eff;
                    end
                    default: begin
                        dec.start_ev = fall;
                        dec.rst_lvl  = trg_eff;
                    end
                endcase
            end
            `TMHL_GRP_MONO: begin
                case (mode_r[2:0])
                    `TMHL_LO_RISE:  dec.start_ev = rise;
                    `TMHL_LO_FALL:  dec.start_ev = fall;
                    `TMHL_LO_ANY:   dec.start_ev = rise | fall;
                    `TMHL_LO_LVL_A: begin
                        dec.start_ev = trg_eff;
                        dec.rst_lvl  = ~trg_eff;
                        dec.clr_run  = 1'b1;
                    end
                    `TMHL_LO_LVL_B: begin
                        dec.start_ev = ~trg_eff;
                        dec.rst_lvl  = trg_eff;
                        dec.clr_run  = 1'b1;
                    end
                    default: dec.hold_all = 1'b1;
                endcase
            end
            default: dec.hold_all = 1'b1;
        endcase
    end

    // ------------------------------------------------------------------------
    // Counter and phase
    // ------------------------------------------------------------------------
    always_comb begin
        count_nxt  = count_r;
        phase_nxt  = phase_r;
        hold_nxt   = hold_r;
        roll       = 1'b0;
        hw_clr_run = 1'b0;
        gate       = run_eff;
        if (mode_r[2:0] == `TMHL_LO_RISE) begin
            gate = run_eff & ~trg_eff;
        end else if (mode_r[2:0] == `TMHL_LO_FALL) begin
            gate = run_eff & trg_eff;
        end
        if (tick && !dec.hold_all) begin
            if (dec.gate_mode) begin
                // A paused tick simply stretches the current period.
                phase_nxt = tmhl_pkg::PH_WAIT;
                if (gate) begin
                    roll      = at_period;
                    count_nxt = at_period ? '0 : count_r + CNT_W'(1);
                end
            end else if (!run_eff) begin
                phase_nxt = tmhl_pkg::PH_WAIT;
            end else begin
                case (phase_r)
                    tmhl_pkg::PH_WAIT: begin
                        if (dec.rst_lvl) begin
                            count_nxt = '0;
                        end else if (dec.start_ev) begin
                            phase_nxt = tmhl_pkg::PH_RUN;
                        end
                    end
                    tmhl_pkg::PH_RUN: begin
                        if (dec.rst_lvl) begin
                            count_nxt = '0;
                            phase_nxt = tmhl_pkg::PH_WAIT;
                        end else if (dec.rst_edge) begin
                            count_nxt = '0;
                            hold_nxt  = `TMHL_RESUME_HOLD;
                            phase_nxt = tmhl_pkg::PH_HOLD;
                        end else if (at_period) begin
                            count_nxt  = '0;
                            roll       = 1'b1;
                            hw_clr_run = dec.clr_run;
                            phase_nxt  = tmhl_pkg::PH_WAIT;
                        end else begin
                            count_nxt = count_r + CNT_W'(1);
                        end
                    end
                    tmhl_pkg::PH_HOLD: begin
                        if (dec.rst_edge) begin
                            hold_nxt = `TMHL_RESUME_HOLD;
                        end else if (hold_r == `TMHL_HOLD_ZERO) begin
                            phase_nxt = tmhl_pkg::PH_RUN;
                            count_nxt = count_r + CNT_W'(1);
                        end else begin
                            hold_nxt = hold_r - 2'h1;
                        end
                    end
                    default: phase_nxt = tmhl_pkg::PH_WAIT;
                endcase
            end
        end
        if (wr_en_i && addr_i == `TMHL_ADDR_COUNT) begin
            count_nxt = wr_data_i[CNT_W-1:0];
        end
    end

    // ------------------------------------------------------------------------
    // Postscaler and registers
    // ------------------------------------------------------------------------
    always_comb begin
        post_nxt  = post_r;
        pscl_nxt  = 1'b0;
        match_nxt = roll;
        if (roll) begin
            if (post_r == ctrl_r.postscale_select) begin
                post_nxt = `TMHL_ZERO4;
                pscl_nxt = 1'b1;
            end else begin
                post_nxt = post_r + `TMHL_ONE4;
            end
        end
        ctrl_nxt   = ctrl_r;
        mode_nxt   = mode_r;
        period_nxt = period_r;
        if (hw_clr_run) begin
            ctrl_nxt.run = 1'b0;
        end
        if (wr_en_i) begin
            case (addr_i)
                `TMHL_ADDR_CTRL: begin
                    // A software write wins over a hardware clear in the same cycle.
                    ctrl_nxt = tmhl_pkg::tmhl_ctrl_t'(wr_data_i);
                    post_nxt = `TMHL_ZERO4;
                end
                `TMHL_ADDR_MODE:   mode_nxt   = wr_data_i[4:0];
                `TMHL_ADDR_PERIOD: period_nxt = wr_data_i[CNT_W-1:0];
                default: ;
            endcase
        end
        rdat_nxt = 8'h00;
        if (rd_en_i) begin
            case (addr_i)
                `TMHL_ADDR_CTRL:   rdat_nxt = ctrl_r;
                `TMHL_ADDR_MODE:   rdat_nxt = {3'h0, mode_r};
                `TMHL_ADDR_PERIOD: rdat_nxt = 8'(period_r);
                `TMHL_ADDR_COUNT:  rdat_nxt = 8'(count_r);
                `TMHL_ADDR_STATUS: rdat_nxt = {5'h0, (phase_r != tmhl_pkg::PH_WAIT),
                                               trg_eff, run_eff};
                default:           rdat_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_r    <= tmhl_pkg::tmhl_ctrl_t'(`TMHL_CTRL_RST);
            mode_r    <= `TMHL_MODE_RST;
            period_r  <= CNT_W'(`TMHL_PERIOD_RST);
            count_r   <= CNT_W'(`TMHL_COUNT_RST);
            phase_r   <= tmhl_pkg::PH_WAIT;
            hold_r    <= `TMHL_HOLD_ZERO;
            pre_r     <= `TMHL_ZERO7;
            post_r    <= `TMHL_ZERO4;
            run_p1_r  <= 1'b0;
            run_p2_r  <= 1'b0;
            trg_p1_r  <= 1'b0;
            trg_p2_r  <= 1'b0;
            trg_prv_r <= 1'b0;
            match_r   <= 1'b0;
            pscl_r    <= 1'b0;
            rdat_r    <= 8'h00;
        end else begin
            ctrl_r    <= ctrl_nxt;
            mode_r    <= mode_nxt;
            period_r  <= period_nxt;
            count_r   <= count_nxt;
            phase_r   <= phase_nxt;
            hold_r    <= hold_nxt;
            pre_r     <= pre_nxt;
            post_r    <= post_nxt;
            run_p1_r  <= run_p1_nxt;
            run_p2_r  <= run_p2_nxt;
            trg_p1_r  <= trg_p1_nxt;
            trg_p2_r  <= trg_p2_nxt;
            trg_prv_r <= trg_prv_nxt;
            match_r   <= match_nxt;
            pscl_r    <= pscl_nxt;
            rdat_r    <= rdat_nxt;
        end
    end

    assign rd_data_o      = rdat_r;
    assign count_value_o  = count_r;
    assign run_o          = ctrl_r.run;
    assign period_match_o = match_r;
    assign postscaled_o   = pscl_r;
endmodule // tmhl_core

// file: core/tmhl_regs.svh
// Purpose: Register offsets, reset values, mode codes and timing counts of the limit timer.
// Assumes: Included by its bare name from every design file that needs it.
// Notes:   Definitions only.
`ifndef TMHL_REGS_SVH
`define TMHL_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define TMHL_ADDR_CTRL    8'h00
`define TMHL_ADDR_MODE    8'h04
`define TMHL_ADDR_PERIOD  8'h08
`define TMHL_ADDR_COUNT   8'h0c
`define TMHL_ADDR_STATUS  8'h10

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TMHL_CTRL_RST     8'h00
`define TMHL_MODE_RST     5'h00
`define TMHL_PERIOD_RST   8'hff
`define TMHL_COUNT_RST    8'h00

// ----------------------------------------------------------------------------
// Mode groups, upper two bits of the mode field
// ----------------------------------------------------------------------------
`define TMHL_GRP_FREE     2'h0
`define TMHL_GRP_ONE      2'h1
`define TMHL_GRP_MONO     2'h2

// ----------------------------------------------------------------------------
// Lower three bits of the mode field
// ----------------------------------------------------------------------------
`define TMHL_LO_SW        3'h0
`define TMHL_LO_RISE      3'h1
`define TMHL_LO_FALL      3'h2
`define TMHL_LO_ANY       3'h3
`define TMHL_LO_ERST_R    3'h4
`define TMHL_LO_ERST_F    3'h5
`define TMHL_LO_LVL_A     3'h6
`define TMHL_LO_LVL_B     3'h7

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
// Extra held ticks after a reset edge, so counting resumes two ticks later.
`define TMHL_RESUME_HOLD  2'h1
`define TMHL_HOLD_ZERO    2'h0
`define TMHL_ONE8         8'h01
`define TMHL_ONE4         4'h1
`define TMHL_ONE7         7'h01
`define TMHL_ZERO7        7'h00
`define TMHL_ZERO4        4'h0

`endif

// file: core/tmhl_pkg.sv
// Purpose: Types shared by the limit timer files.
// Assumes: Nothing is imported; users write tmhl_pkg::name.
// Notes:   Constants live in tmhl_regs.svh.
package tmhl_pkg;

    // ------------------------------------------------------------------------
    // Control register layout
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic       run;
        logic [2:0] prescale_select;
        logic [3:0] postscale_select;
    } tmhl_ctrl_t;

    // ------------------------------------------------------------------------
    // Decoded behaviour of the selected mode
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic gate_mode;
        logic start_ev;
        logic rst_edge;
        logic rst_lvl;
        logic clr_run;
        logic hold_all;
    } tmhl_dec_t;

    typedef enum logic [1:0] {
        PH_WAIT,
        PH_RUN,
        PH_HOLD
    } tmhl_phase_t;

endpackage

// file: core/tmhl_sync.sv
// Purpose: Three-stage synchroniser for one asynchronous level.
// Assumes: Single clock core_clk_i.
// Notes:   Output follows only once stages two and three agree.
module tmhl_sync (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic sys_rst_i,
    // Level
    input  wire logic async_i,
    output logic      sync_o
);
    logic [2:0] stg_r;
    logic [2:0] stg_nxt;
    logic       out_r;
    logic       out_nxt;

    always_comb begin
        stg_nxt = {stg_r[1:0], async_i};
        out_nxt = (stg_r[1] == stg_r[2]) ? stg_r[2] : out_r;
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stg_r <= 3'h0;
            out_r <= 1'b0;
        end else begin
            stg_r <= stg_nxt;
            out_r <= out_nxt;
        end
    end

    assign sync_o = out_r;
endmodule // tmhl_sync

// file: verif/tmhl_core_assertions.sv
// Purpose: Port-level checks of the limit timer mode control.
// Assumes: Mode, period and prescale select are snooped from register writes.
// Notes:   Stepping checks hold only while the prescale select is zero.
`include "tmhl_regs.svh"
module tmhl_core_chk #(
    parameter int CNT_W = 8
) (
    input wire logic             core_clk_i,
    input wire logic             sys_rst_i,
    input wire logic [7:0]       addr_i,
    input wire logic [7:0]       wr_data_i,
    input wire logic             wr_en_i,
    input wire logic             rd_en_i,
    input wire logic [7:0]       rd_data_o,
    input wire logic             ext_trigger_signal_i,
    input wire logic             instr_clk_sel_i,
    input wire logic             debug_mode_i,
    input wire logic [CNT_W-1:0] count_value_o,
    input wire logic             run_o,
    input wire logic             period_match_o,
    input wire logic             postscaled_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] mode_r, mode_nxt;
    logic [7:0] per_r, per_nxt;
    logic [6:0] ps_r, ps_nxt;
    always_comb begin
        mode_nxt = (wr_en_i && addr_i == `TMHL_ADDR_MODE) ? wr_data_i[4:0] : mode_r;
        per_nxt  = (wr_en_i && addr_i == `TMHL_ADDR_PERIOD) ? wr_data_i : per_r;
        ps_nxt   = (wr_en_i && addr_i == `TMHL_ADDR_CTRL) ? wr_data_i[6:0] : ps_r;
    end
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_r <= `TMHL_MODE_RST;
            per_r  <= `TMHL_PERIOD_RST;
            ps_r   <= 7'h00;
        end else begin
            mode_r <= mode_nxt;
            per_r  <= per_nxt;
            ps_r   <= ps_nxt;
        end
    end
    wire sw0  = mode_r == 5'h00 && ps_r[6:4] == 3'h0;
    wire hi   = mode_r == 5'h01 && !debug_mode_i && ext_trigger_signal_i;
    wire lo   = mode_r == 5'h02 && !debug_mode_i && !ext_trigger_signal_i;
    wire os   = mode_r[4:3] == 2'h1 || mode_r inside {5'h16, 5'h17};
    wire mono = mode_r inside {5'h11, 5'h12, 5'h13};
    wire rsv  = mode_r[4:3] == 2'h3 || mode_r inside {5'h10, 5'h14, 5'h15};
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    AST_SW_STEP: assert property ((sw0 && run_o) [*5] ##0 !$past(wr_en_i) |->
        count_value_o == ($past(count_value_o) == CNT_W'(per_r) ? '0 : $past(count_value_o) + 1'b1))
        else $error("count did not step while running");
    AST_WRAP: assert property (period_match_o |->
        $past(count_value_o) == CNT_W'(per_r) && count_value_o == '0)
        else $error("rollover not from period to zero");
    AST_GATE_HI: assert property (hi [*8] ##0 !$past(wr_en_i) |-> $stable(count_value_o))
        else $error("count moved while gated high");
    AST_GATE_LO: assert property (lo [*8] ##0 !$past(wr_en_i) |-> $stable(count_value_o))
        else $error("count moved while gated low");
    AST_OS_CLR: assert property (os && period_match_o |-> !run_o && count_value_o == '0)
        else $error("one-shot did not stop at zero with run clear");
    AST_MONO_KEEP: assert property (mono && period_match_o |-> run_o && count_value_o == '0)
        else $error("monostable lost run or count");
    AST_RUN_SYNC: assert property (!instr_clk_sel_i && sw0 && $rose(run_o) |->
        $stable(count_value_o) [*3])
        else $error("run took effect too early");
    AST_RUN_FAST: assert property (instr_clk_sel_i && sw0 && $rose(run_o) |->
        $stable(count_value_o) [*2] ##1 count_value_o != $past(count_value_o))
        else $error("run not applied in next period");
    AST_RES_HOLD: assert property (rsv && $past(rsv) && !$past(wr_en_i) |->
        $stable(count_value_o))
        else $error("count moved in reserved mode");
    AST_POST_ONE: assert property (ps_r == 7'h00 |-> postscaled_o == period_match_o)
        else $error("postscaler not one to one");
    COV_MATCH: cover property (period_match_o);
    COV_MONO: cover property (mono && period_match_o);
    COV_DEBUG: cover property (debug_mode_i && $changed(ext_trigger_signal_i));
endmodule // tmhl_core_chk
bind tmhl_core tmhl_core_chk #(.CNT_W(CNT_W)) u_chk (.core_clk_i, .sys_rst_i, .addr_i,
    .wr_data_i, .wr_en_i, .rd_en_i, .rd_data_o, .ext_trigger_signal_i, .instr_clk_sel_i,
    .debug_mode_i, .count_value_o, .run_o, .period_match_o, .postscaled_o);

// file: verif/tmhl_trig_src.sv
// Purpose: Model of the logic that drives the external trigger.
// Assumes: The bench requests levels; this model decides when they appear.
// Notes:   A larger GAP models a slower source.
module tmhl_trig_src #(
    parameter int GAP = 6
) (
    input  wire logic core_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic lvl_i,
    output logic      trig_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int held;
    // A change waits until the old level has stood GAP+1 clocks, so edges stay spaced.
    always @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            trig_o <= 1'b0;
            held   <= 0;
        end else if (lvl_i != trig_o && held >= GAP) begin
            trig_o <= lvl_i;
            held   <= 0;
        end else
            held <= held + 1;
    end
endmodule // tmhl_trig_src

// file: verif/test_timer_hw_limit_mode_control.sv
// Purpose: Self-checking bench of the limit timer mode control.
// Assumes: Prescale select stays zero, so one tick is one clock.
// Notes:   Reads note expected data in a queue that the monitor drains.
`include "tmhl_regs.svh"
module test_timer_hw_limit_mode_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic       core_clk_i = 1'b0, sys_rst_i = 1'b1, wr_en_i = 1'b0, rd_en_i = 1'b0;
    logic       instr_clk_sel_i = 1'b0, debug_mode_i = 1'b0, lvl = 1'b0, rd_pend = 1'b0;
    logic [7:0] addr_i = 8'h00, wr_data_i = 8'h00, rd_data_o, count_value_o, p, exp_q[$];
    logic       ext_trigger_signal_i, run_o, period_match_o, postscaled_o;
    int         mismatches = 0, n_compared = 0, mcnt = 0, n, base;
    logic [4:0] em[7] = '{5'h08, 5'h09, 5'h0a, 5'h0b, 5'h11, 5'h12, 5'h13};
    logic [4:0] lm[4] = '{5'h0e, 5'h0f, 5'h16, 5'h17};
    logic [4:0] rm[5] = '{5'h10, 5'h14, 5'h15, 5'h18, 5'h1f};
    always #10 core_clk_i = ~core_clk_i;
    tmhl_core u_dut (.core_clk_i, .sys_rst_i, .addr_i, .wr_data_i, .wr_en_i, .rd_en_i,
        .rd_data_o, .ext_trigger_signal_i, .instr_clk_sel_i, .debug_mode_i,
        .count_value_o, .run_o, .period_match_o, .postscaled_o);
    tmhl_trig_src u_src (.core_clk_i, .sys_rst_i, .lvl_i(lvl), .trig_o(ext_trigger_signal_i));
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        if (!w)
            exp_q.push_back(d);
        @(posedge core_clk_i);
        addr_i    <= a;
        wr_data_i <= d;
        wr_en_i   <= w;
        rd_en_i   <= !w;
        @(posedge core_clk_i);
        wr_en_i   <= 1'b0;
        rd_en_i   <= 1'b0;
    endtask
    always @(negedge core_clk_i) begin
        if (rd_pend)
            check("rd_data_o", rd_data_o, exp_q.pop_front());
        if (period_match_o === 1'b1)
            mcnt++;
        rd_pend = rd_en_i;
    end
    task automatic wait_match(input int lim);
        int m0 = mcnt;
        n  = 0;
        while (mcnt == m0 && n < lim) begin
            @(posedge core_clk_i);
            n++;
        end
        check("period_match_o", 8'(mcnt - m0), 8'h01);
    endtask
    task automatic setup(input logic [4:0] m, input logic l, input logic s);
        @(posedge core_clk_i);
        lvl             <= l;
        instr_clk_sel_i <= s;
        debug_mode_i    <= 1'b0;
        bus(1'b1, `TMHL_ADDR_CTRL, 8'h00);
        bus(1'b1, `TMHL_ADDR_MODE, {3'h0, m});
        bus(1'b1, `TMHL_ADDR_PERIOD, p);
        bus(1'b1, `TMHL_ADDR_COUNT, 8'h00);
        repeat (12) @(posedge core_clk_i);
    endtask
    task automatic on();
        bus(1'b1, `TMHL_ADDR_CTRL, 8'h80);
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        void'($urandom(34));
        repeat (4) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        bus(1'b0, `TMHL_ADDR_CTRL, 8'h00);
        bus(1'b0, `TMHL_ADDR_PERIOD, 8'hff);
        bus(1'b0, 8'h20, 8'h00);
        $display("done reset values");
        p = 8'(6 + $urandom % 10);
        for (int s = 0; s < 2; s++) begin
            setup(5'h00, 1'b0, s[0]);
            on();
            wait_match(p + 20);
            wait_match(p + 20);
            check("period", 8'(n), p + 8'h01);
        end
        $display("done software gate");
        for (int k = 1; k < 3; k++) begin
            setup(5'(k), k == 1, 1'b0);
            on();
            repeat (40) @(posedge core_clk_i);
            bus(1'b0, `TMHL_ADDR_COUNT, 8'h00);
            lvl <= k != 1;
            wait_match(p + 20);
            debug_mode_i <= 1'b1;
            lvl          <= k == 1;
            wait_match(p + 20);
            wait_match(p + 20);
        end
        $display("done hardware gate");
        foreach (em[i]) begin
            setup(em[i], em[i][1:0] == 2'h2, 1'b1);
            on();
            if (em[i][2:0] != 3'h0) begin
                repeat (12) @(posedge core_clk_i);
                bus(1'b0, `TMHL_ADDR_COUNT, 8'h00);
                lvl <= !lvl;
            end
            wait_match(p + 20);
            bus(1'b0, `TMHL_ADDR_CTRL, {em[i][4], 7'h00});
        end
        $display("done edge start");
        p = 8'h28;
        for (int k = 0; k < 2; k++) begin
            setup(5'h0c + 5'(k), k[0], 1'b0);
            on();
            base = mcnt;
            repeat (8) begin
                repeat (10) @(posedge core_clk_i);
                lvl <= !lvl;
            end
            check("early match", 8'(mcnt - base), 8'h00);
            wait_match(60);
        end
        $display("done edge reset");
        p = 8'(6 + $urandom % 10);
        foreach (lm[i]) begin
            setup(lm[i], lm[i][0], 1'b0);
            on();
            repeat (40) @(posedge core_clk_i);
            bus(1'b0, `TMHL_ADDR_COUNT, 8'h00);
            lvl <= !lvl;
            wait_match(p + 20);
        end
        $display("done level modes");
        foreach (rm[i]) begin
            setup(rm[i], 1'b0, 1'b0);
            on();
            lvl <= 1'b1;
            repeat (30) @(posedge core_clk_i);
            bus(1'b0, `TMHL_ADDR_COUNT, 8'h00);
        end
        $display("done reserved modes");
        end_of_test();
    end
    // The run needs some two thousand clocks; twenty thousand leaves ample margin.
    initial begin
        #400us;
        mismatches++;
        end_of_test();
    end
endmodule // test_timer_hw_limit_mode_control
